// ===== hw/codec_interrupt_gen.sv
`timescale 1ns/1ns
// Operation
// - ADC D6 high while below noise threshold
// - ADC D4 shows engine standard port
// - ADC D3 shows engine auxiliary port
// - ADC D2 shows DC data available
// - Config D7 enables headset insertion event
// - Config D6 enables button press event
// - Config D5 enables compressor power event
// - Config D4 enables gain-loop noise event
// - Config D3 enables short-circuit event
// - Config D2 enables engine interrupt event
// - Config D1 enables DC data event
// - D0 clear: one 2 ms pulse
// - D0 set: 2 ms pulses, 4 ms period
// - Repeat stops after both sticky reads
// - Sticky DAC flags at index 44
// - Sticky ADC flags at index 45
module codec_interrupt_gen
  import codec_irq_pkg::*;
#(
  parameter int PULSE_CYCLES = int'(PULSE_CYC),
  parameter int PERIOD_CYCLES = int'(PERIOD_CYC)
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [codec_irq_pkg::ADDR_W+1:0] paddr,
  input wire logic [codec_irq_pkg::DATA_W-1:0] pwdata,
  output logic [codec_irq_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic short_det,
  input wire logic button_det,
  input wire logic insert_det,
  input wire logic compr_above,
  input wire logic noise_below,
  input wire logic dac_std_port,
  input wire logic dac_aux_port,
  input wire logic adc_std_port,
  input wire logic adc_aux_port,
  input wire logic dc_meas_avail,
  output logic irq_out_a,
  output logic irq_out_b,
  output logic irq
);
  import codec_irq_pkg::*;

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    HIGH = 3'b010,
    LOW = 3'b100
  } pulse_state_type;

  logic [7:0] cfg_q [2];
  logic [7:0] dac_sticky_q, adc_sticky_q;
  logic [7:0] dac_live, adc_live;
  logic [ST_W-1:0] st_q, mask_q;
  logic [7:0] prev_dac_q, prev_adc_q;
  logic rd_dac_q, rd_adc_q;
  logic [7:0] idx;
  logic wr_en, rd_en, hit;
  logic [7:0] rd_val;
  pulse_state_type ps_q [2];
  logic [CNT_W-1:0] cnt_q [2];
  logic [1:0] start, pulse_begin;
  logic [7:0] dac_rise, adc_rise, dac_set;

  function automatic logic events_hit(input logic [7:0] cfg, input logic [7:0] dn,
                                      input logic [7:0] an);
    events_hit = (cfg[CFG_INSERT] & dn[DF_INSERT])
               | (cfg[CFG_BUTTON] & dn[DF_BUTTON])
               | (cfg[CFG_COMPR] & dn[DF_COMPR])
               | (cfg[CFG_NOISE] & an[AF_NOISE])
               | (cfg[CFG_SHORT] & dn[DF_SHORT])
               | (cfg[CFG_ENGINE] & (dn[DF_STD] | dn[DF_AUX] | an[AF_STD] | an[AF_AUX]))
               | (cfg[CFG_DCMEAS] & an[AF_DCMEAS]);
  endfunction : events_hit

  always_comb
  begin
    dac_live = 8'h00;
    dac_live[DF_SHORT] = short_det;
    dac_live[DF_BUTTON] = button_det;
    dac_live[DF_INSERT] = insert_det;
    dac_live[DF_COMPR] = compr_above;
    dac_live[DF_STD] = dac_std_port;
    dac_live[DF_AUX] = dac_aux_port;
    adc_live = 8'h00;
    adc_live[AF_NOISE] = noise_below;
    adc_live[AF_STD] = adc_std_port;
    adc_live[AF_AUX] = adc_aux_port;
    adc_live[AF_DCMEAS] = dc_meas_avail;
  end

  // Rising edges start pulses; the sticky headset bit also records a removal
  assign dac_rise = dac_live & ~prev_dac_q;
  assign adc_rise = adc_live & ~prev_adc_q;

  always_comb
  begin
    dac_set = dac_rise;
    dac_set[DF_INSERT] = dac_live[DF_INSERT] ^ prev_dac_q[DF_INSERT];
  end

  // Zero-wait APB slave
  assign idx = paddr[ADDR_W+1:2];
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  always_comb
  begin
    hit = 1'b1;
    rd_val = 8'h00;
    unique case (idx)
      IDX_DAC_STICKY: rd_val = dac_sticky_q;
      IDX_ADC_STICKY: rd_val = adc_sticky_q;
      IDX_DAC_LIVE: rd_val = dac_live;
      IDX_ADC_LIVE: rd_val = adc_live;
      IDX_CFG_A: rd_val = cfg_q[0];
      IDX_CFG_B: rd_val = cfg_q[1];
      IDX_RSVD: rd_val = RSVD_RESET;
      IDX_IRQ_STATUS: rd_val = {{(REG_W-ST_W){1'b0}}, st_q};
      IDX_IRQ_MASK: rd_val = {{(REG_W-ST_W){1'b0}}, mask_q};
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~hit;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      // Captured in the setup phase so the data stand at the access edge
      prdata <= {{(DATA_W-REG_W){1'b0}}, rd_val};
  end

  // The reserved register is not stored: writes are dropped, reads give zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_q[0] <= CFG_RESET;
      cfg_q[1] <= CFG_RESET;
      mask_q <= '0;
    end
    else if (wr_en)
    begin
      if (idx == IDX_CFG_A)
        cfg_q[0] <= pwdata[REG_W-1:0];
      if (idx == IDX_CFG_B)
        cfg_q[1] <= pwdata[REG_W-1:0];
      if (idx == IDX_IRQ_MASK)
        mask_q <= pwdata[ST_W-1:0];
    end
  end

  // Sticky flags: edges set, a read clears only what it reported, set wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prev_dac_q <= 8'h00;
      prev_adc_q <= 8'h00;
      dac_sticky_q <= 8'h00;
      adc_sticky_q <= 8'h00;
    end
    else
    begin
      prev_dac_q <= dac_live;
      prev_adc_q <= adc_live;
      dac_sticky_q <= (dac_sticky_q
                       & ~((rd_en && idx == IDX_DAC_STICKY) ? prdata[REG_W-1:0] : 8'h00))
                      | dac_set;
      adc_sticky_q <= (adc_sticky_q
                       & ~((rd_en && idx == IDX_ADC_STICKY) ? prdata[REG_W-1:0] : 8'h00))
                      | adc_rise;
    end
  end

  // Both sticky registers must be read since the train began
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_dac_q <= 1'b0;
      rd_adc_q <= 1'b0;
    end
    else if (|start)
    begin
      rd_dac_q <= 1'b0;
      rd_adc_q <= 1'b0;
    end
    else
    begin
      if (rd_en && idx == IDX_DAC_STICKY)
        rd_dac_q <= 1'b1;
      if (rd_en && idx == IDX_ADC_STICKY)
        rd_adc_q <= 1'b1;
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : gen_out
    // Edge of any enabled live event starts a sequence while the output is idle
    assign start[g] = events_hit(cfg_q[g], dac_rise, adc_rise) & (ps_q[g] == IDLE);
    assign pulse_begin[g] = start[g] | ((ps_q[g] == LOW)
                            && cnt_q[g] == CNT_W'(PERIOD_CYCLES - 1)
                            && !(rd_dac_q && rd_adc_q) && cfg_q[g][CFG_REPEAT]);

    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        ps_q[g] <= IDLE;
        cnt_q[g] <= '0;
      end
      else
      begin
        unique case (ps_q[g])
          IDLE:
            if (start[g])
            begin
              ps_q[g] <= HIGH;
              cnt_q[g] <= '0;
            end
          HIGH:
          begin
            cnt_q[g] <= cnt_q[g] + 1'b1;
            if (cnt_q[g] == CNT_W'(PULSE_CYCLES - 1))
              ps_q[g] <= cfg_q[g][CFG_REPEAT] ? LOW : IDLE;
          end
          LOW:
          begin
            cnt_q[g] <= cnt_q[g] + 1'b1;
            if (cnt_q[g] == CNT_W'(PERIOD_CYCLES - 1))
            begin
              cnt_q[g] <= '0;
              if (rd_dac_q && rd_adc_q || !cfg_q[g][CFG_REPEAT])
                ps_q[g] <= IDLE;
              else
                ps_q[g] <= HIGH;
            end
          end
          default: ps_q[g] <= IDLE;
        endcase
      end
    end
  end

  assign irq_out_a = (ps_q[0] == HIGH);
  assign irq_out_b = (ps_q[1] == HIGH);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= (st_q & ~((wr_en && idx == IDX_IRQ_STATUS) ? pwdata[ST_W-1:0] : '0))
              | pulse_begin;
  end
  assign irq = |(st_q & mask_q);

  a_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(irq_out_a) |-> irq_out_a [*8])
    else $error("irq_out_a pulse too short");
  a_single_end: assert property (@(posedge clk) disable iff (!rst_n)
    (ps_q[0] == HIGH && cnt_q[0] == CNT_W'(PULSE_CYCLES - 1) && !cfg_q[0][CFG_REPEAT])
    |=> ps_q[0] == IDLE)
    else $error("single pulse did not end");
  a_repeat_low: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(irq_out_b) && cfg_q[1][CFG_REPEAT] |-> ps_q[1] == LOW)
    else $error("repeat gap missing");
  a_start_enabled: assert property (@(posedge clk) disable iff (!rst_n)
    start[0] |=> irq_out_a)
    else $error("enabled event gave no pulse");
  a_noise_flag: assert property (@(posedge clk) disable iff (!rst_n)
    adc_live[AF_NOISE] == noise_below)
    else $error("noise flag wrong");
  a_insert_mask: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_q[0] == 8'h00) |-> !start[0])
    else $error("disabled event started pulse");
  a_sticky_set: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(short_det) |=> dac_sticky_q[DF_SHORT])
    else $error("sticky short flag lost");
  a_sticky_adc: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dc_meas_avail) |=> adc_sticky_q[AF_DCMEAS])
    else $error("sticky dc flag lost");
  a_stop_reads: assert property (@(posedge clk) disable iff (!rst_n)
    (ps_q[0] == LOW && rd_dac_q && rd_adc_q && !start[0]) |=> ps_q[0] != HIGH)
    else $error("train continued after reads");
  c_single: cover property (@(posedge clk) disable iff (!rst_n) $fell(irq_out_a));
  c_repeat: cover property (@(posedge clk) disable iff (!rst_n)
    ps_q[1] == LOW ##1 ps_q[1] == HIGH);
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
  c_both_read: cover property (@(posedge clk) disable iff (!rst_n)
    rd_dac_q && rd_adc_q && ps_q[1] == LOW);

  // Checker helpers: length of the running high phase and time since the last rise
  logic [1:0] out_now, out_was_q;
  logic [CNT_W-1:0] hi_run_q [2];
  logic [CNT_W-1:0] since_rise_q [2];

  assign out_now = {irq_out_b, irq_out_a};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_was_q <= 2'b00;
      for (int k = 0; k < 2; k++)
      begin
        hi_run_q[k] <= '0;
        since_rise_q[k] <= '0;
      end
    end
    else
    begin
      out_was_q <= out_now;
      for (int k = 0; k < 2; k++)
      begin
        hi_run_q[k] <= out_now[k] ? hi_run_q[k] + 1'b1 : '0;
        // Saturates so that a long idle time never looks like a fresh period
        if (out_now[k] && !out_was_q[k])
          since_rise_q[k] <= CNT_W'(1);
        else if (since_rise_q[k] != '1)
          since_rise_q[k] <= since_rise_q[k] + 1'b1;
      end
    end
  end

  a_width_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    (out_was_q[0] && !irq_out_a) |-> hi_run_q[0] == CNT_W'(PULSE_CYCLES))
    else $error("irq_out_a pulse width wrong");
  a_width_full_b: assert property (@(posedge clk) disable iff (!rst_n)
    (out_was_q[1] && !irq_out_b) |-> hi_run_q[1] == CNT_W'(PULSE_CYCLES))
    else $error("irq_out_b pulse width wrong");
  a_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ps_q[0] == LOW) ##1 (ps_q[0] == HIGH) |-> since_rise_q[0] == CNT_W'(PERIOD_CYCLES))
    else $error("irq_out_a period wrong");
  a_period_b: assert property (@(posedge clk) disable iff (!rst_n)
    (ps_q[1] == LOW) ##1 (ps_q[1] == HIGH) |-> since_rise_q[1] == CNT_W'(PERIOD_CYCLES))
    else $error("irq_out_b period wrong");
  a_std_read: assert property (@(posedge clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && idx == IDX_ADC_LIVE) |=> prdata[AF_STD] == $past(adc_std_port))
    else $error("standard port flag wrong");
  a_aux_read: assert property (@(posedge clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && idx == IDX_ADC_LIVE) |=> prdata[AF_AUX] == $past(adc_aux_port))
    else $error("auxiliary port flag wrong");
  a_dc_read: assert property (@(posedge clk) disable iff (!rst_n)
    (psel && !penable && !pwrite && idx == IDX_ADC_LIVE) |=> prdata[AF_DCMEAS] == $past(dc_meas_avail))
    else $error("dc availability flag wrong");
  a_insert_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ps_q[0] == IDLE && cfg_q[0] == (8'h01 << CFG_INSERT) && dac_rise[DF_INSERT]) |=> irq_out_a)
    else $error("insertion event gave no pulse");
  a_button_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ps_q[0] == IDLE && cfg_q[0] == (8'h01 << CFG_BUTTON) && dac_rise[DF_BUTTON]) |=> irq_out_a)
    else $error("button event gave no pulse");
  a_compr_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ps_q[0] == IDLE && cfg_q[0] == (8'h01 << CFG_COMPR) && dac_rise[DF_COMPR]) |=> irq_out_a)
    else $error("compressor event gave no pulse");
  a_noise_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ps_q[0] == IDLE && cfg_q[0] == (8'h01 << CFG_NOISE) && adc_rise[AF_NOISE]) |=> irq_out_a)
    else $error("noise event gave no pulse");
  a_short_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ps_q[0] == IDLE && cfg_q[0] == (8'h01 << CFG_SHORT) && dac_rise[DF_SHORT]) |=> irq_out_a)
    else $error("short event gave no pulse");
  a_engine_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ps_q[0] == IDLE && cfg_q[0] == (8'h01 << CFG_ENGINE) && dac_rise[DF_STD]) |=> irq_out_a)
    else $error("engine event gave no pulse");
  a_dc_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ps_q[0] == IDLE && cfg_q[0] == (8'h01 << CFG_DCMEAS) && adc_rise[AF_DCMEAS]) |=> irq_out_a)
    else $error("dc event gave no pulse");
  a_insert_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (insert_det != prev_dac_q[DF_INSERT]) |=> dac_sticky_q[DF_INSERT])
    else $error("headset change not recorded");
  a_status_set: assert property (@(posedge clk) disable iff (!rst_n)
    pulse_begin[0] |=> st_q[ST_PULSE_A])
    else $error("pulse start not in status");
  a_read_upper: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en |-> prdata[DATA_W-1:REG_W] == '0)
    else $error("upper read bits not zero");
endmodule : codec_interrupt_gen

// ===== hw/codec_irq_pkg.sv
package codec_irq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DAC_STICKY = 8'h2c;
  localparam logic [7:0] IDX_ADC_STICKY = 8'h2d;
  localparam logic [7:0] IDX_DAC_LIVE = 8'h2e;
  localparam logic [7:0] IDX_ADC_LIVE = 8'h2f;
  localparam logic [7:0] IDX_CFG_A = 8'h30;
  localparam logic [7:0] IDX_CFG_B = 8'h31;
  localparam logic [7:0] IDX_RSVD = 8'h32;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h38;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h39;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] RSVD_RESET = 8'h00;
  // Config bit positions
  localparam int CFG_INSERT = 7;
  localparam int CFG_BUTTON = 6;
  localparam int CFG_COMPR = 5;
  localparam int CFG_NOISE = 4;
  localparam int CFG_SHORT = 3;
  localparam int CFG_ENGINE = 2;
  localparam int CFG_DCMEAS = 1;
  localparam int CFG_REPEAT = 0;
  // DAC flag bit positions
  localparam int DF_SHORT = 7;
  localparam int DF_BUTTON = 5;
  localparam int DF_INSERT = 4;
  localparam int DF_COMPR = 3;
  localparam int DF_STD = 1;
  localparam int DF_AUX = 0;
  // ADC flag bit positions
  localparam int AF_NOISE = 6;
  localparam int AF_STD = 4;
  localparam int AF_AUX = 3;
  localparam int AF_DCMEAS = 2;
  // Status bits for the APB interrupt
  localparam int ST_PULSE_A = 0;
  localparam int ST_PULSE_B = 1;
  localparam int ST_W = 2;
  // Timing
  localparam longint CLK_HZ = 100_000_000;
  localparam longint PULSE_US = 2000;
  localparam longint PERIOD_US = 4000;
  localparam longint PULSE_CYC = PULSE_US * CLK_HZ / 1_000_000;
  localparam longint PERIOD_CYC = PERIOD_US * CLK_HZ / 1_000_000;
  localparam int CNT_W = 24;
endpackage : codec_irq_pkg

// ===== testbench/irq_pulse_watch.sv
`timescale 1ns/1ns
// Host side of one interrupt line: counts pulses and keeps the last pulse width
module irq_pulse_watch (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level,
  output int count_q,
  output int width_q
);
  int run_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_q <= 0;
      width_q <= 0;
      run_q <= 0;
    end
    else
    begin
      run_q <= level ? run_q + 1 : 0;
      if (level && run_q == 0)
        count_q <= count_q + 1;
      // Width is only known once the line has dropped again
      if (!level && run_q != 0)
        width_q <= run_q;
    end
  end
endmodule : irq_pulse_watch

// ===== testbench/codec_interrupt_gen_test.sv
`timescale 1ns/1ns
module codec_interrupt_gen_test;
  import codec_irq_pkg::*;
  localparam int PW = 10;
  localparam int PP = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  // Event inputs: short, button, insert, compr, noise, dac std/aux, adc std/aux, dc
  logic [9:0] ev = 10'h000;
  wire [31:0] prdata;
  wire pready, pslverr, irq_out_a, irq_out_b, irq;
  int fail_count = 0;
  int n_tests = 0;
  int cnt_a, w_a, cnt_b, w_b;
  always #5 clk = ~clk;
  codec_interrupt_gen #(.PULSE_CYCLES(PW), .PERIOD_CYCLES(PP)) codec_interrupt_gen_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .short_det(ev[0]), .button_det(ev[1]), .insert_det(ev[2]), .compr_above(ev[3]),
    .noise_below(ev[4]), .dac_std_port(ev[5]), .dac_aux_port(ev[6]),
    .adc_std_port(ev[7]), .adc_aux_port(ev[8]), .dc_meas_avail(ev[9]),
    .irq_out_a(irq_out_a), .irq_out_b(irq_out_b), .irq(irq));
  irq_pulse_watch irq_pulse_watch_a_i (.clk(clk), .rst_n(rst_n), .level(irq_out_a),
    .count_q(cnt_a), .width_q(w_a));
  irq_pulse_watch irq_pulse_watch_b_i (.clk(clk), .rst_n(rst_n), .level(irq_out_b),
    .count_q(cnt_b), .width_q(w_b));
  task close_out;
    $display("mismatches %0d comparisons %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      close_out();
    end
    // Response and read data are taken at the access edge itself
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr
  task rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    check(what, exp, r);
  endtask : rd_chk
  task t_reset;
    rd_chk("cfg_a reset", IDX_CFG_A, 32'h0);
    rd_chk("cfg_b reset", IDX_CFG_B, 32'h0);
    wr(IDX_RSVD, 32'h0);
    rd_chk("reserved", IDX_RSVD, 32'h0);
  endtask : t_reset
  task t_live;
    ev <= 10'h290;
    repeat (2) @(posedge clk);
    rd_chk("adc live 1", IDX_ADC_LIVE, 32'h54);
    ev <= 10'h380;
    repeat (2) @(posedge clk);
    rd_chk("adc live 2", IDX_ADC_LIVE, 32'h1c);
    ev <= 10'h000;
  endtask : t_live
  task t_sources;
    int bitpos[7] = '{CFG_INSERT, CFG_BUTTON, CFG_COMPR, CFG_NOISE, CFG_SHORT, CFG_ENGINE,
                      CFG_DCMEAS};
    int src[7] = '{2, 1, 3, 4, 0, 5, 9};
    int c;
    int cb;
    for (int i = 0; i < 7; i++)
    begin
      wr(IDX_CFG_A, 32'h1 << bitpos[i]);
      rd_chk("cfg_a", IDX_CFG_A, 32'h1 << bitpos[i]);
      c = cnt_a;
      cb = cnt_b;
      ev[src[(i + 1) % 7]] <= 1'b1;
      repeat (40) @(posedge clk);
      check("masked source", c, cnt_a);
      ev <= 10'h000;
      @(posedge clk);
      ev[src[i]] <= 1'b1;
      repeat (60) @(posedge clk);
      check("single pulse", c + 1, cnt_a);
      check("pulse width", PW, w_a);
      check("other output", cb, cnt_b);
      ev <= 10'h000;
      @(posedge clk);
    end
    wr(IDX_CFG_A, 32'h0);
  endtask : t_sources
  task t_repeat;
    int c;
    // Clear what earlier scenarios left in the sticky flags
    rd_chk("dac sticky old", IDX_DAC_STICKY, 32'hba);
    rd_chk("adc sticky old", IDX_ADC_STICKY, 32'h5c);
    wr(IDX_CFG_B, (32'h1 << CFG_SHORT) | 32'h1);
    c = cnt_b;
    ev[0] <= 1'b1;
    repeat (100) @(posedge clk);
    check("train started", 1, (cnt_b - c) >= 3);
    check("train width", PW, w_b);
    rd_chk("dac sticky", IDX_DAC_STICKY, 32'h80);
    c = cnt_b;
    repeat (70) @(posedge clk);
    check("one read not enough", 1, cnt_b > c);
    rd_chk("adc sticky", IDX_ADC_STICKY, 32'h0);
    repeat (70) @(posedge clk);
    c = cnt_b;
    repeat (100) @(posedge clk);
    check("train stopped", c, cnt_b);
    ev <= 10'h000;
  endtask : t_repeat
  task t_irq;
    logic [31:0] r;
    logic e;
    wr(IDX_IRQ_MASK, 32'h3);
    @(posedge clk);
    check("irq unmasked", 1, irq);
    wr(IDX_IRQ_MASK, 32'h0);
    @(posedge clk);
    check("irq masked", 0, irq);
    wr(IDX_IRQ_MASK, 32'h3);
    wr(IDX_IRQ_STATUS, 32'h3);
    @(posedge clk);
    check("irq cleared", 0, irq);
    rd_chk("status cleared", IDX_IRQ_STATUS, 32'h0);
    apb(1'b0, 8'h3f, 32'h0, r, e);
    check("unmapped error", 1, e);
  endtask : t_irq
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_live();
    t_sources();
    t_repeat();
    t_irq();
    close_out();
  end
endmodule : codec_interrupt_gen_test
